/* File: shared/lpdg_map.svh */
// constants for the low power mode and debug command gate
// assumes inclusion by the gate package and core module only
`ifndef LPDG_MAP_SVH
`define LPDG_MAP_SVH
// debug command codes, 3 bits
`define LPDG_CMD_MEM       3'h0
`define LPDG_CMD_MEM_STAT  3'h1
`define LPDG_CMD_DREG      3'h2
`define LPDG_CMD_BKGND     3'h3
`define LPDG_CMD_CPUREG    3'h4
`define LPDG_CMD_TRACE     3'h5
`define LPDG_CMD_RESUME    3'h6
// command answer status codes, 2 bits
`define LPDG_ST_OK         2'h0
`define LPDG_ST_LOWPWR     2'h1
`define LPDG_ST_ILLEGAL    2'h2
// stop depth codes, 2 bits, none outside stop
`define LPDG_DEPTH_NONE    2'h0
`define LPDG_DEPTH_LIGHT   2'h2
`define LPDG_DEPTH_DEEP    2'h3
// reset value of the cpu interrupt mask
`define LPDG_IMASK_RST     1'b1
`endif

/* File: shared/lpdg_pkg.sv */
// types for the low power mode and debug command gate
// assumes lpdg_map.svh is on the include path
`include "lpdg_map.svh"
package lpdg_pkg;
   typedef enum logic [4:0] {
      LPDG_RUN  = 5'h01,
      LPDG_WAIT = 5'h02,
      LPDG_STOP = 5'h04,
      LPDG_BDM  = 5'h08,
      LPDG_STEP = 5'h10
   } lpdg_mode_t;
endpackage

/* File: core/lpdg_gate.sv */
// run, wait and stop mode control with background command gating
// assumes one 20 MHz clock; debug pin already decoded to commands
`timescale 1ns/1ps
`default_nettype none
`include "lpdg_map.svh"
module lpdg_gate
   import lpdg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wait_exec,
   input wire logic stop_exec,
   input wire logic stop_enable_bit,
   input wire logic stop_mode_sel,
   input wire logic refclk_keep_cfg,
   input wire logic irq_req,
   input wire logic wake_req,
   input wire logic imask_set,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   output logic cmd_exec,
   output logic [1:0] cmd_status_r,
   output logic cmd_done_r,
   output logic cpu_clk_en_r,
   output logic bus_clk_en_r,
   output logic refclk_en_r,
   output logic imask_r,
   output logic stack_start_r,
   output logic step_go_r,
   output logic illegal_stop_r,
   output logic [1:0] stop_depth_r,
   output lpdg_mode_t mode_r
);
   // next values of the registered outputs
   lpdg_mode_t mode_nxt;
   logic [1:0] cmd_status_nxt;
   logic [1:0] stop_depth_nxt;
   logic cmd_done_nxt, imask_nxt, stack_start_nxt, step_go_nxt;
   logic illegal_stop_nxt;
   // clock gate terms and command classes
   logic cpu_on, bus_on, ref_on;
   logic is_nonint, is_active, low_pwr;

   // command classes
   function automatic logic nonintrusive(input logic [2:0] c);
      nonintrusive = (c == `LPDG_CMD_MEM) || (c == `LPDG_CMD_MEM_STAT)
         || (c == `LPDG_CMD_DREG) || (c == `LPDG_CMD_BKGND);
   endfunction

   // commands that need the cpu halted
   function automatic logic active_bg(input logic [2:0] c);
      active_bg = (c == `LPDG_CMD_CPUREG) || (c == `LPDG_CMD_TRACE)
         || (c == `LPDG_CMD_RESUME);
   endfunction

   // command gating; cmd_exec tells the memory path to perform access
   always_comb
   begin
      is_nonint = nonintrusive(cmd_code);
      is_active = active_bg(cmd_code);
      low_pwr = (mode_r == LPDG_WAIT) || (mode_r == LPDG_STOP);
      // defaults: no access, ok status, no done pulse
      cmd_exec = 1'b0;
      cmd_status_nxt = `LPDG_ST_OK;
      cmd_done_nxt = 1'b0;
      if (cmd_valid)
      begin
         cmd_done_nxt = 1'b1;
         if (low_pwr)
         begin
            // while asleep status reads answer low power without access; only background in wait executes
            if (cmd_code == `LPDG_CMD_MEM_STAT)
               cmd_status_nxt = `LPDG_ST_LOWPWR;
            // a halt in stop is refused; only wait may be woken
            else if (cmd_code == `LPDG_CMD_BKGND &&
                     mode_r == LPDG_WAIT)
               cmd_exec = 1'b1;
            else
               cmd_status_nxt = `LPDG_ST_ILLEGAL;
         end
         // awake: non-intrusive always, cpu commands when halted
         else if (is_nonint)
            cmd_exec = 1'b1;
         else if (is_active && mode_r == LPDG_BDM)
            cmd_exec = 1'b1;
         else
            cmd_status_nxt = `LPDG_ST_ILLEGAL;
      end
   end

   // mode sequencing
   always_comb
   begin
      mode_nxt = mode_r;
      imask_nxt = imask_r;
      stack_start_nxt = 1'b0;
      step_go_nxt = 1'b0;
      illegal_stop_nxt = 1'b0;
      stop_depth_nxt = stop_depth_r;
      // cpu may set the mask; a wait entry below overrides it
      if (imask_set)
         imask_nxt = 1'b1;
      case (mode_r)
         LPDG_RUN:
         begin
            // priority: halt request, then wait, then stop
            if (cmd_exec && cmd_code == `LPDG_CMD_BKGND)
               mode_nxt = LPDG_BDM;
            else if (wait_exec)
            begin
               mode_nxt = LPDG_WAIT;
               imask_nxt = 1'b0;
            end
            else if (stop_exec && stop_enable_bit)
            begin
               mode_nxt = LPDG_STOP;
               // depth is latched at entry, sel may move later
               if (stop_mode_sel)
                  stop_depth_nxt = `LPDG_DEPTH_DEEP;
               else
                  stop_depth_nxt = `LPDG_DEPTH_LIGHT;
            end
            else if (stop_exec)
               illegal_stop_nxt = 1'b1;
         end
         LPDG_WAIT:
         begin
            // background wins over a coincident interrupt
            if (cmd_exec && cmd_code == `LPDG_CMD_BKGND)
               mode_nxt = LPDG_BDM;
            else if (irq_req)
            begin
               mode_nxt = LPDG_RUN;
               stack_start_nxt = 1'b1;
            end
         end
         LPDG_STOP:
         begin
            // wake source is outside this block
            if (wake_req || irq_req)
            begin
               // an irq exit also starts stacking, a wake does not
               mode_nxt = LPDG_RUN;
               stack_start_nxt = irq_req;
               stop_depth_nxt = `LPDG_DEPTH_NONE;
            end
         end
         LPDG_BDM:
         begin
            // resume outranks trace; both need cmd_exec
            if (cmd_exec && cmd_code == `LPDG_CMD_RESUME)
               mode_nxt = LPDG_RUN;
            else if (cmd_exec && cmd_code == `LPDG_CMD_TRACE)
            begin
               mode_nxt = LPDG_STEP;
               step_go_nxt = 1'b1;
            end
         end
         // the cpu executes a single instruction here
         LPDG_STEP:
            mode_nxt = LPDG_BDM; // one instruction, then halt again
         // unreachable one-hot codes recover to run
         default:
            mode_nxt = LPDG_RUN;
      endcase
      // clocks follow the next mode so gating is glitch free
      cpu_on = (mode_nxt == LPDG_RUN) || (mode_nxt == LPDG_STEP)
         || (mode_nxt == LPDG_BDM);
      bus_on = mode_nxt != LPDG_STOP;
      ref_on = (mode_nxt != LPDG_STOP) || refclk_keep_cfg;
   end

   // state registers
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_r <= LPDG_RUN;
         imask_r <= `LPDG_IMASK_RST;
         stack_start_r <= 1'b0;
         step_go_r <= 1'b0;
         illegal_stop_r <= 1'b0;
         stop_depth_r <= `LPDG_DEPTH_NONE;
         // clocks run out of reset so the cpu can fetch
         cmd_status_r <= `LPDG_ST_OK;
         cmd_done_r <= 1'b0;
         cpu_clk_en_r <= 1'b1;
         bus_clk_en_r <= 1'b1;
         refclk_en_r <= 1'b1;
      end
      // every registered output follows its next value each edge
      else
      begin
         mode_r <= mode_nxt;
         imask_r <= imask_nxt;
         stack_start_r <= stack_start_nxt;
         step_go_r <= step_go_nxt;
         illegal_stop_r <= illegal_stop_nxt;
         stop_depth_r <= stop_depth_nxt;
         cmd_status_r <= cmd_status_nxt;
         cmd_done_r <= cmd_done_nxt;
         cpu_clk_en_r <= cpu_on;
         bus_clk_en_r <= bus_on;
         refclk_en_r <= ref_on;
      end
   end
endmodule // lpdg_gate
`default_nettype wire

/* File: tb/lpdg_host.sv */
// debug host model feeding decoded background commands
// assumes the bench sets req, code and rude after a clock edge
`timescale 1ns/1ps
`default_nettype none
module lpdg_host
(
   input wire logic in_wait,
   input wire logic rude,
   input wire logic req,
   input wire logic [2:0] code,
   output logic cmd_valid,
   output logic [2:0] cmd_code
);
   // a polite host sends only halt or status during wait
   assign cmd_valid = req;
   assign cmd_code = (in_wait && !rude && code != 3'h3) ? 3'h1 : code;
endmodule // lpdg_host
`default_nettype wire

/* File: tb/lpdg_gate_assertions.sv */
// assertions on lpdg_gate ports
// assumes one clock and async active low reset
`timescale 1ns/1ps
`default_nettype none
module lpdg_chk
   import lpdg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wait_exec,
   input wire logic stop_exec,
   input wire logic stop_enable_bit,
   input wire logic irq_req,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   input wire logic cmd_exec,
   input wire logic [1:0] cmd_status_r,
   input wire logic cpu_clk_en_r,
   input wire logic imask_r,
   input wire logic stack_start_r,
   input wire logic illegal_stop_r,
   input wire lpdg_mode_t mode_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // halt request outranks wait and stop events
   wire bk = cmd_valid && cmd_code == 3'h3;
   wire run = mode_r == LPDG_RUN;
   wire wt = mode_r == LPDG_WAIT;
   wire sp = mode_r == LPDG_STOP;
   property p_wt; run && wait_exec && !bk |=> wt && !imask_r && !cpu_clk_en_r;
   endproperty
   a_wt: assert property (p_wt) else $error("wait entry");
   property p_iq; wt && irq_req && !bk |=> run && stack_start_r; endproperty
   a_iq: assert property (p_iq) else $error("wait irq exit");
   property p_ms; (wt || sp) && cmd_valid && cmd_code == 3'h1 |=>
      cmd_status_r == 2'h1; endproperty
   a_ms: assert property (p_ms) else $error("status access");
   property p_bk; wt && bk |=> mode_r == LPDG_BDM; endproperty
   a_bk: assert property (p_bk) else $error("halt from wait");
   property p_ab; mode_r != LPDG_BDM && cmd_valid && cmd_code > 3'h3 |->
      !cmd_exec; endproperty
   a_ab: assert property (p_ab) else $error("cpu cmd");
   property p_go; mode_r == LPDG_BDM && cmd_valid && cmd_code == 3'h6 |=> run;
   endproperty
   a_go: assert property (p_go) else $error("resume");
   property p_sp; run && stop_exec && !wait_exec && !bk |=>
      sp == $past(stop_enable_bit) && illegal_stop_r == !sp; endproperty
   a_sp: assert property (p_sp) else $error("stop");
   property p_ni; run && cmd_valid && cmd_code < 3'h4 |-> cmd_exec; endproperty
   a_ni: assert property (p_ni) else $error("run cmd");
   cover property (wt && irq_req);
   cover property (sp);
   cover property (mode_r == LPDG_BDM && cmd_valid && cmd_code == 3'h6);
endmodule // lpdg_chk
bind lpdg_gate lpdg_chk u_chk (.*);
`default_nettype wire

/* File: tb/low_power_mode_debug_gate_tb.sv */
// bench for lpdg_gate: random stimulus against an integer mode model
// assumes gate, host model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
$display("unexpected %0t got %h exp %h", $time, a, b); end end
module low_power_mode_debug_gate_tb
   import lpdg_pkg::*;
;
logic clock = 0, rst_n = 0, wait_exec = 0, stop_exec = 0, stop_enable_bit = 0;
logic irq_req = 0, wake_req = 0, imask_set = 0, req = 0, rude = 0;
logic cmd_valid, cmd_exec, cmd_done_r, cpu_clk_en_r, bus_clk_en_r;
logic refclk_en_r, imask_r, stack_start_r, step_go_r, illegal_stop_r;
logic [2:0] code = 0, cmd_code;
logic [1:0] cmd_status_r, stop_depth_r;
logic [31:0] r;
lpdg_mode_t mode_r;
int error_cnt = 0, n_checks = 0, seed = 78211, m = 1, mn = 1, s, sn = 0;
int x, c, v, bk;
int ex, d = 0, dn = 0, en = 1, enn = 1, pv = 0, psk = 0, pil = 0, psg = 0;
logic stop_mode_sel = 0, refclk_keep_cfg = 0;
always #25 clock = ~clock;
// stop depth and reference clock keep are random levels
lpdg_gate dut (.*);
lpdg_host host (.in_wait(m == 2), .rude(rude), .req(req), .code(code),
   .cmd_valid(cmd_valid), .cmd_code(cmd_code));
task close_out;
   $display("checks %0d mismatches %0d", n_checks, error_cnt);
   if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
   else
      $display("RESULT: FAIL");
   $finish;
endtask
initial
begin
   #500000;
   error_cnt++;
   close_out;
end
initial
begin
   repeat (4) @(posedge clock);
   #1 rst_n = 1;
   repeat (3000)
   begin
      @(posedge clock);
      #1;
      m = mn;
      s = sn;
      d = dn;
      en = enn;
      `CHK(mode_r, m[4:0])
      `CHK(cmd_status_r, s[1:0])
      `CHK(cpu_clk_en_r, m != 2 && m != 4)
      ex = (m != 4) * 8 + en * 4 + d;
      `CHK({bus_clk_en_r, refclk_en_r, stop_depth_r}, ex[3:0])
      `CHK(cmd_done_r, pv[0])
      `CHK(stack_start_r, psk[0])
      `CHK(illegal_stop_r, pil[0])
      `CHK(step_go_r, psg[0])
      if (m == 2) `CHK(imask_r, 1'b0)
      r = $random(seed);
      wait_exec = m == 1 && r[1:0] == 0;
      stop_exec = m == 1 && r[3:2] == 0;
      stop_enable_bit = r[4];
      irq_req = r[5] && m < 5;
      wake_req = r[6] && m == 4;
      imask_set = r[7] && m == 1;
      rude = r[8];
      req = r[9] && m != 16;
      code = r[12:10] == 3'h7 ? 3'h6 : r[12:10];
      stop_mode_sel = r[13];
      refclk_keep_cfg = r[14];
      #1;
      v = cmd_valid;
      c = cmd_code;
      x = v && (m == 1 ? c < 4 : m == 2 ? c == 3 : m == 8);
      `CHK(cmd_exec, x[0])
      sn = !v ? 0 : (m == 2 || m == 4) && c == 1 ? 1 : x ? 0 : 2;
      bk = v && c == 3;
      mn = m == 1 ? (bk ? 8 : wait_exec ? 2 : stop_exec && stop_enable_bit ? 4 : 1)
         : m == 2 ? (bk ? 8 : irq_req ? 1 : 2)
         : m == 4 ? (wake_req || irq_req ? 1 : 4)
         : m == 8 ? (v && c == 6 ? 1 : v && c == 5 ? 16 : 8) : 8;
      pv = v;
      psk = (m == 2 && !bk && irq_req) || (m == 4 && irq_req);
      pil = m == 1 && !bk && !wait_exec && stop_exec && !stop_enable_bit;
      psg = m == 8 && v && c == 5;
      dn = mn != 4 ? 0 : m == 4 ? d : stop_mode_sel ? 3 : 2;
      enn = mn != 4 || refclk_keep_cfg;
   end
   $display("random mode walk done");
   close_out;
end
endmodule // low_power_mode_debug_gate_tb
`default_nettype wire
